// File: rtl/pi_arb_pkg.sv
// constants, register map and state type for the interpolator port arbiter
package pi_arb_pkg;

    // clock and update pacing
    localparam int CLK_HZ = 50_000_000;
    localparam int PI_UPDATE_DIV = 5;
    localparam int PI_UPD_CNT_W = 3;

    // transceiver configuration port widths
    localparam int CFG_ADDR_W = 8;
    localparam int CFG_DATA_W = 16;

    // loop number ranges: error +/-2^19, tune +/-2^20
    localparam int ERR_W = 21;
    localparam int TUNE_W = 22;
    localparam logic signed [63:0] ERR_MAX = 64'sh0000_0000_0008_0000;
    localparam logic signed [63:0] TUNE_MAX = 64'sh0000_0000_0010_0000;
    localparam logic [TUNE_W-1:0] SD_FULL = 22'h10_0000;

    // wishbone register map, byte addresses
    localparam int WB_ADDR_W = 8;
    localparam int WB_DATA_W = 32;
    localparam logic [WB_ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [WB_ADDR_W-1:0] REG_DIV = 8'h04;
    localparam logic [WB_ADDR_W-1:0] REG_OFFSET = 8'h08;
    localparam logic [WB_ADDR_W-1:0] REG_STATUS = 8'h0c;
    localparam logic [WB_ADDR_W-1:0] REG_ERROR = 8'h10;
    localparam logic [WB_ADDR_W-1:0] REG_TUNE = 8'h14;

    // control fields
    localparam int CTRL_OFFSET_EN_BIT = 0;
    localparam int CTRL_HOLD_BIT = 1;
    localparam int CTRL_G1_LSB = 4;
    localparam int CTRL_G2_LSB = 12;
    localparam int GAIN_W = 5;
    localparam int DIV_W = 16;
    localparam int DIV_REF_LSB = 0;
    localparam int DIV_LOC_LSB = 16;

    // status fields
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_GRANT_BIT = 1;
    localparam int STAT_HALT_BIT = 2;
    localparam int STAT_CODE_LSB = 8;

    // reset values
    localparam logic [WB_DATA_W-1:0] CTRL_RST = 32'h0000_4020;
    localparam logic [WB_DATA_W-1:0] DIV_RST = 32'h0010_0010;
    localparam logic [WB_DATA_W-1:0] OFFSET_RST = 32'h0000_0000;

    typedef enum logic [1:0] {
        ARB_IDLE = 2'b00,
        ARB_LOOP = 2'b01,
        ARB_USER = 2'b11
    } arb_state_t;

endpackage

// File: rtl/ref_sync.sv
// two-flop synchroniser for levels arriving from another clock
`timescale 1ns/1ps
`default_nettype none
module ref_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta;

    if (W < 1) begin : g_bad_width
        $error("ref_sync: width must be at least one");
    end

    // first stage feeds only the second stage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta <= '0;
            q_o <= '0;
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule
`default_nettype wire

// File: rtl/pi_cfg_arbiter.sv
// interpolator loop driving the transceiver config port, shared with a user port
`timescale 1ns/1ps
`default_nettype none
module pi_cfg_arbiter
    import pi_arb_pkg::*;
#(
    parameter int PI_PHASES = 120,
    parameter int PI_CODE_W = 7,
    parameter logic [CFG_ADDR_W-1:0] PI_CODE_ADDR = 8'h00
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ref_clk_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [WB_ADDR_W-1:0] wb_adr_i,
    input wire logic [WB_DATA_W-1:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [WB_DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    output logic cfg_enable_o,
    output logic cfg_write_enable_o,
    output logic [CFG_DATA_W-1:0] cfg_write_data_o,
    output logic [CFG_ADDR_W-1:0] cfg_address_o,
    input wire logic cfg_ready_i,
    input wire logic user_req_i,
    input wire logic user_cfg_enable_i,
    input wire logic user_cfg_write_enable_i,
    input wire logic [CFG_ADDR_W-1:0] user_cfg_address_i,
    input wire logic [CFG_DATA_W-1:0] user_cfg_write_data_i,
    output logic user_cfg_ready_mirror_o,
    output logic cfg_port_busy_o
);
    // parameter checks at elaboration, before any logic is built
    if (PI_PHASES < 2 || PI_PHASES > (1 << PI_CODE_W)) begin : g_bad_phases
        $error("pi_cfg_arbiter: phase count does not fit the code width");
    end
    if (PI_CODE_W > CFG_DATA_W) begin : g_bad_code_w
        $error("pi_cfg_arbiter: code wider than port data");
    end
    if (PI_UPDATE_DIV < 1 || PI_UPDATE_DIV > (1 << PI_UPD_CNT_W)) begin : g_bad_upd_div
        $error("pi_cfg_arbiter: update divider does not fit its counter");
    end
    if (TUNE_W <= ERR_W) begin : g_bad_tune_w
        $error("pi_cfg_arbiter: tune value must be wider than the error");
    end

    localparam logic [PI_CODE_W-1:0] CODE_LAST = PI_CODE_W'(PI_PHASES - 1);
    localparam logic [PI_UPD_CNT_W-1:0] UPD_LAST = PI_UPD_CNT_W'(PI_UPDATE_DIV - 1);

    // software registers
    logic [WB_DATA_W-1:0] ctrl;
    logic [WB_DATA_W-1:0] div;
    logic [WB_DATA_W-1:0] offset;

    // loop state
    logic ref_s;
    logic ref_d;
    logic [DIV_W-1:0] ref_cnt;
    logic [DIV_W-1:0] loc_cnt;
    logic signed [ERR_W-1:0] err;
    logic signed [TUNE_W-1:0] integ;
    logic [TUNE_W-1:0] sd_acc;
    logic [PI_UPD_CNT_W-1:0] upd_cnt;
    logic [PI_CODE_W-1:0] code;
    logic pend_wr;
    logic halted;
    arb_state_t state;

    // reference is foreign to clk_i, so it is synchronised before use
    ref_sync #(.W(1)) u_ref_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(ref_clk_i),
        .q_o(ref_s)
    );

    // control field decode
    wire offset_en = ctrl[CTRL_OFFSET_EN_BIT];
    wire hold = ctrl[CTRL_HOLD_BIT];
    wire [GAIN_W-1:0] g1 = ctrl[CTRL_G1_LSB +: GAIN_W];
    wire [GAIN_W-1:0] g2 = ctrl[CTRL_G2_LSB +: GAIN_W];
    wire [DIV_W-1:0] ref_div = div[DIV_REF_LSB +: DIV_W];
    wire [DIV_W-1:0] loc_div = div[DIV_LOC_LSB +: DIV_W];
    wire signed [TUNE_W-1:0] offset_val = offset[TUNE_W-1:0];

    // loop timing: a divisor of zero behaves as one
    wire running = !halted && !user_req_i;
    wire ref_rise = ref_s && !ref_d;
    wire ref_tick = ref_rise && (ref_cnt + 16'h0001 >= ref_div);
    wire loc_tick = (loc_cnt + 16'h0001 >= loc_div);
    wire upd_tick = (upd_cnt == UPD_LAST);

    // phase detector, saturating at +/-2^19
    wire signed [63:0] err_sum = 64'(err) + (ref_tick ? 64'sd1 : 64'sd0)
                               - (loc_tick ? 64'sd1 : 64'sd0);
    wire signed [63:0] err_sat = (err_sum > ERR_MAX) ? ERR_MAX :
                                 (err_sum < -ERR_MAX) ? -ERR_MAX : err_sum;

    // proportional-integral filter, saturating at +/-2^20
    wire signed [63:0] err_wide = 64'(err);
    wire signed [63:0] integ_sum = 64'(integ) + (err_wide <<< g2);
    wire signed [63:0] integ_sat = (integ_sum > TUNE_MAX) ? TUNE_MAX :
                                   (integ_sum < -TUNE_MAX) ? -TUNE_MAX : integ_sum;
    wire signed [63:0] tune_sum = 64'(integ) + (err_wide <<< g1);
    wire signed [63:0] tune_sat = (tune_sum > TUNE_MAX) ? TUNE_MAX :
                                  (tune_sum < -TUNE_MAX) ? -TUNE_MAX : tune_sum;
    wire signed [TUNE_W-1:0] tune = offset_en ? offset_val : tune_sat[TUNE_W-1:0];

    // first-order sigma-delta turns the tune value into a step rate
    wire tune_neg = tune[TUNE_W-1];
    wire [TUNE_W-1:0] tune_mag = tune_neg ? TUNE_W'(-tune) : TUNE_W'(tune);
    // at most one step per update, so larger magnitudes are clamped; this keeps
    // the accumulator below full and stops it from wrapping
    wire [TUNE_W-1:0] step_mag = (tune_mag > SD_FULL) ? SD_FULL : tune_mag;
    wire [TUNE_W-1:0] sd_sum = sd_acc + step_mag;
    wire sd_step = upd_tick && (sd_sum >= SD_FULL);
    wire [TUNE_W-1:0] next_sd_acc = !upd_tick ? sd_acc :
                                    sd_step ? sd_sum - SD_FULL : sd_sum;

    // positive tune shortens periods by walking the code down
    wire [PI_CODE_W-1:0] code_dn = (code == '0) ? CODE_LAST : code - 1'b1;
    wire [PI_CODE_W-1:0] code_up = (code == CODE_LAST) ? '0 : code + 1'b1;
    wire [PI_CODE_W-1:0] next_code = tune_neg ? code_up : code_dn;

    // arbitration: the user wins an idle port at once,
    // the loop only starts a write from idle
    wire granted = (state == ARB_USER);
    wire issue_loop = (state == ARB_IDLE) && pend_wr && running;
    arb_state_t next_state;
    always_comb begin
        next_state = state;
        case (state)
            ARB_IDLE: begin
                if (user_req_i) next_state = ARB_USER;
                else if (issue_loop) next_state = ARB_LOOP;
            end
            // an outstanding loop write finishes before the user gets the port
            ARB_LOOP: begin
                if (cfg_ready_i) next_state = user_req_i ? ARB_USER : ARB_IDLE;
            end
            ARB_USER: begin
                if (!user_req_i) next_state = ARB_IDLE;
            end
            default: next_state = ARB_IDLE;
        endcase
    end

    // port drive selection
    wire next_cfg_en = granted ? user_cfg_enable_i : issue_loop;
    wire next_cfg_we = granted ? user_cfg_write_enable_i : issue_loop;
    wire [CFG_ADDR_W-1:0] next_cfg_addr = granted ? user_cfg_address_i : PI_CODE_ADDR;
    wire [CFG_DATA_W-1:0] next_cfg_data = granted ? user_cfg_write_data_i :
                                          CFG_DATA_W'(code);
    wire next_mirror = granted && cfg_ready_i;
    wire next_busy = (next_state != ARB_USER);

    // wishbone decode
    wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // writes land at the edge where the master samples ack, its request still held
    wire wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    wire [WB_DATA_W-1:0] byte_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                                      {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire wr_ctrl = wb_wr && (wb_adr_i == REG_CTRL);
    wire wr_div = wb_wr && (wb_adr_i == REG_DIV);
    wire wr_offset = wb_wr && (wb_adr_i == REG_OFFSET);
    wire [WB_DATA_W-1:0] next_ctrl = (ctrl & ~byte_mask) | (wb_dat_i & byte_mask);
    wire [WB_DATA_W-1:0] next_div = (div & ~byte_mask) | (wb_dat_i & byte_mask);
    wire [WB_DATA_W-1:0] next_offset = (offset & ~byte_mask) | (wb_dat_i & byte_mask);
    wire [WB_DATA_W-1:0] status_word = (WB_DATA_W'(code) << STAT_CODE_LSB)
                                     | (WB_DATA_W'(halted) << STAT_HALT_BIT)
                                     | (WB_DATA_W'(granted) << STAT_GRANT_BIT)
                                     | (WB_DATA_W'(cfg_port_busy_o) << STAT_BUSY_BIT);
    // unmapped addresses still ack, reading zero, so a stray access never hangs
    wire [WB_DATA_W-1:0] next_rd =
        (wb_adr_i == REG_CTRL) ? ctrl :
        (wb_adr_i == REG_DIV) ? div :
        (wb_adr_i == REG_OFFSET) ? offset :
        (wb_adr_i == REG_STATUS) ? status_word :
        (wb_adr_i == REG_ERROR) ? WB_DATA_W'(unsigned'(err)) :
        (wb_adr_i == REG_TUNE) ? WB_DATA_W'(unsigned'(tune)) : '0;

    // bus slave: one-cycle ack, read data only in the ack cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_req ? next_rd : '0;
        end
    end

    // software registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= CTRL_RST;
            div <= DIV_RST;
            offset <= OFFSET_RST;
        end else begin
            if (wr_ctrl) ctrl <= next_ctrl;
            if (wr_div) div <= next_div;
            if (wr_offset) offset <= next_offset;
        end
    end

    // reference edges, divided down to the detector rate
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref_d <= 1'b0;
            ref_cnt <= '0;
        end else begin
            ref_d <= ref_s;
            if (ref_rise) ref_cnt <= ref_tick ? '0 : ref_cnt + 1'b1;
        end
    end

    // local divider and interpolator update pacing
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            loc_cnt <= '0;
            upd_cnt <= '0;
        end else begin
            loc_cnt <= loc_tick ? '0 : loc_cnt + 1'b1;
            upd_cnt <= upd_tick ? '0 : upd_cnt + 1'b1;
        end
    end

    // detector, filter and modulator; frozen once halted
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            err <= '0;
            integ <= '0;
            sd_acc <= '0;
        end else if (running) begin
            err <= err_sat[ERR_W-1:0];
            if (loc_tick && !hold) integ <= integ_sat[TUNE_W-1:0];
            sd_acc <= next_sd_acc;
        end
    end

    // phase code and pending write; a new step while one is pending and not yet issued merges
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            code <= '0;
            pend_wr <= 1'b0;
        end else if (running && sd_step) begin
            code <= next_code;
            pend_wr <= 1'b1;
        end else if (issue_loop) begin
            pend_wr <= 1'b0;
        end
    end

    // halt is sticky: only a reset pulse brings the loop back
    always_ff @(posedge clk_i) begin
        if (rst_i) halted <= 1'b0;
        else if (user_req_i) halted <= 1'b1;
    end

    // arbiter state
    always_ff @(posedge clk_i) begin
        if (rst_i) state <= ARB_IDLE;
        else state <= next_state;
    end

    // registered port outputs, so every pin comes straight from a flop
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_enable_o <= 1'b0;
            cfg_write_enable_o <= 1'b0;
            cfg_address_o <= '0;
            cfg_write_data_o <= '0;
            user_cfg_ready_mirror_o <= 1'b0;
            cfg_port_busy_o <= 1'b1;
        end else begin
            cfg_enable_o <= next_cfg_en;
            cfg_write_enable_o <= next_cfg_we;
            cfg_address_o <= next_cfg_addr;
            cfg_write_data_o <= next_cfg_data;
            user_cfg_ready_mirror_o <= next_mirror;
            cfg_port_busy_o <= next_busy;
        end
    end
endmodule
`default_nettype wire

// File: dv/pi_cfg_monitor.sv
// checker for the interpolator port arbiter
`timescale 1ns/1ps
`default_nettype none
module pi_cfg_monitor
    import pi_arb_pkg::*;
#(
    parameter logic [CFG_ADDR_W-1:0] PI_CODE_ADDR = 8'h00
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cfg_enable_o,
    input wire logic cfg_write_enable_o,
    input wire logic [CFG_DATA_W-1:0] cfg_write_data_o,
    input wire logic [CFG_ADDR_W-1:0] cfg_address_o,
    input wire logic cfg_ready_i,
    input wire logic user_req_i,
    input wire logic user_cfg_enable_i,
    input wire logic user_cfg_write_enable_i,
    input wire logic [CFG_ADDR_W-1:0] user_cfg_address_i,
    input wire logic [CFG_DATA_W-1:0] user_cfg_write_data_i,
    input wire logic user_cfg_ready_mirror_o,
    input wire logic cfg_port_busy_o
);
    logic halted;
    // sticky until reset, so a late loop write after user access is caught
    always_ff @(posedge clk_i) begin
        if (rst_i) halted <= 1'b0;
        else if (user_req_i) halted <= 1'b1;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    reset_state_a: assert property ($fell(rst_i) |-> cfg_port_busy_o && !cfg_enable_o
        && !user_cfg_ready_mirror_o) else $error("outputs not idle after reset");
    loop_write_a: assert property (cfg_enable_o && cfg_port_busy_o
        |-> cfg_write_enable_o ##1 !cfg_enable_o) else $error("loop strobe not a write pulse");
    loop_addr_a: assert property (cfg_enable_o && cfg_port_busy_o
        |-> cfg_address_o == PI_CODE_ADDR) else $error("loop write to wrong address");
    user_route_a: assert property (user_req_i && !cfg_port_busy_o && user_cfg_enable_i
        |=> cfg_enable_o && cfg_address_o == $past(user_cfg_address_i)
        && cfg_write_data_o == $past(user_cfg_write_data_i)
        && cfg_write_enable_o == $past(user_cfg_write_enable_i)) else $error("user access lost");
    mirror_follow_a: assert property (user_req_i && !cfg_port_busy_o && cfg_ready_i
        |=> user_cfg_ready_mirror_o) else $error("ready not mirrored");
    mirror_cause_a: assert property (user_cfg_ready_mirror_o
        |-> $past(cfg_ready_i) && $past(user_req_i)) else $error("mirror without ready");
    busy_release_a: assert property (!user_req_i |=> cfg_port_busy_o)
        else $error("busy low without request");
    grant_bound_a: assert property ($rose(user_req_i) |-> ##[1:20] !cfg_port_busy_o)
        else $error("grant too late");
    halt_hold_a: assert property (halted && !user_req_i |-> !cfg_enable_o)
        else $error("loop ran while halted");
    cover property (user_req_i && !cfg_port_busy_o && user_cfg_enable_i);
    cover property (user_cfg_ready_mirror_o);
    cover property (cfg_enable_o && cfg_port_busy_o);
endmodule
bind pi_cfg_arbiter pi_cfg_monitor #(.PI_CODE_ADDR(PI_CODE_ADDR)) mon (.clk_i, .rst_i,
    .cfg_enable_o, .cfg_write_enable_o, .cfg_write_data_o, .cfg_address_o, .cfg_ready_i,
    .user_req_i, .user_cfg_enable_i, .user_cfg_write_enable_i, .user_cfg_address_i,
    .user_cfg_write_data_i, .user_cfg_ready_mirror_o, .cfg_port_busy_o);
`default_nettype wire

// File: dv/xcvr_cfg_model.sv
// transceiver configuration port model answering each access accepted while idle with a ready pulse
`timescale 1ns/1ps
`default_nettype none
module xcvr_cfg_model (
    input wire logic clk_i,
    input wire logic en_i,
    input wire logic slow_i,
    output logic rdy_o
);
    int wait_left = 0;
    initial rdy_o = 1'b0;
    // one access at a time; an enable while busy is dropped, as the port would
    always @(posedge clk_i) begin
        rdy_o <= (wait_left == 1);
        if (wait_left > 0) wait_left <= wait_left - 1;
        else if (en_i) wait_left <= slow_i ? 6 : 2;
    end
endmodule
`default_nettype wire

// File: dv/phase_interp_cfg_port_arbiter_tb_top.sv
// testbench for the interpolator port arbiter
`timescale 1ns/1ps
`default_nettype none
module phase_interp_cfg_port_arbiter_tb_top;
    import pi_arb_pkg::*;
    typedef struct {logic we; logic [7:0] adr; logic [31:0] dat; logic [3:0] sel;
        logic [31:0] exp;} row_t;
    logic clk_i = 0, rst_i = 1, ref_clk_i = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [7:0] wb_adr_i = 0, user_cfg_address_i = 0;
    logic [31:0] wb_dat_i = 0, wb_dat_o, rd;
    logic [3:0] wb_sel_i = 0;
    logic [15:0] user_cfg_write_data_i = 0, cfg_write_data_o, prev_code;
    logic [7:0] cfg_address_o;
    logic wb_ack_o, cfg_enable_o, cfg_write_enable_o, cfg_ready_i, user_req_i = 0;
    logic user_cfg_enable_i = 0, user_cfg_write_enable_i = 0, user_cfg_ready_mirror_o;
    logic cfg_port_busy_o, slow = 0, track = 0, have_prev = 0, dec = 1;
    int mismatches = 0, samples_checked = 0, cycles = 0, moves = 0, n;
    row_t rows[11] = '{'{0, REG_CTRL, 0, 4'hf, CTRL_RST}, '{0, REG_DIV, 0, 4'hf, DIV_RST},
        '{0, REG_OFFSET, 0, 4'hf, OFFSET_RST}, '{0, 8'h20, 0, 4'hf, 0},
        '{1, 8'h20, 32'hffff_ffff, 4'hf, 0}, '{0, 8'h20, 0, 4'hf, 0},
        '{1, REG_DIV, 32'h0003_0005, 4'hf, 0}, '{0, REG_DIV, 0, 4'hf, 32'h0003_0005},
        '{1, REG_OFFSET, 32'h0010_0000, 4'hf, 0}, '{1, REG_OFFSET, 32'h0000_00aa, 4'h1, 0},
        '{0, REG_OFFSET, 0, 4'hf, 32'h0010_00aa}};
    pi_cfg_arbiter uut (.clk_i, .rst_i, .ref_clk_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .cfg_enable_o, .cfg_write_enable_o,
        .cfg_write_data_o, .cfg_address_o, .cfg_ready_i, .user_req_i, .user_cfg_enable_i,
        .user_cfg_write_enable_i, .user_cfg_address_i, .user_cfg_write_data_i,
        .user_cfg_ready_mirror_o, .cfg_port_busy_o);
    xcvr_cfg_model partner (.clk_i, .en_i(cfg_enable_o), .slow_i(slow), .rdy_o(cfg_ready_i));
    always #10 clk_i = ~clk_i;
    always #27 ref_clk_i = ~ref_clk_i;
    task automatic summarize();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
            input logic [3:0] sel);
        @(posedge clk_i);
        wb_cyc_i <= 1;
        wb_stb_i <= 1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= sel;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 0;
        wb_stb_i <= 0;
    endtask
    task automatic user_acc(input logic we, input logic [7:0] adr, input logic [15:0] dat,
            input logic ok);
        @(posedge clk_i);
        user_cfg_enable_i <= 1;
        user_cfg_write_enable_i <= we;
        user_cfg_address_i <= adr;
        user_cfg_write_data_i <= dat;
        @(posedge clk_i);
        user_cfg_enable_i <= 0;
        @(negedge clk_i);
        if (ok) check({cfg_enable_o, cfg_write_enable_o, cfg_address_o, cfg_write_data_o},
            {1'b1, we, adr, dat});
        else check({cfg_enable_o, cfg_write_enable_o}, 2'b00);
        n = 0;
        while (ok && user_cfg_ready_mirror_o !== 1'b1 && ++n < 20) @(negedge clk_i);
        if (!ok) repeat (8) @(negedge clk_i);
        check(user_cfg_ready_mirror_o, ok);
    endtask
    // loop codes must step one phase at a time, wrapping over 120 phases
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            summarize();
        end
        if (cfg_enable_o && cfg_port_busy_o && track) begin
            if (have_prev && cfg_write_data_o != prev_code) begin
                moves++;
                check(cfg_write_data_o, dec ? (prev_code == 0 ? 16'h77 : prev_code - 1)
                    : (prev_code == 16'h77 ? 16'h0 : prev_code + 1));
            end
            prev_code = cfg_write_data_o;
            have_prev = 1;
        end
    end
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 0;
        @(negedge clk_i);
        check({cfg_port_busy_o, cfg_enable_o, user_cfg_ready_mirror_o}, 3'b100);
        foreach (rows[i]) begin
            wb(rows[i].we, rows[i].adr, rows[i].dat, rows[i].sel);
            if (!rows[i].we) check(rd, rows[i].exp);
        end
        wb(1, REG_OFFSET, 32'h0010_0000, 4'hf);
        wb(1, REG_CTRL, CTRL_RST | 32'h1, 4'hf);
        repeat (12) @(posedge clk_i);
        track = 1;
        repeat (300) @(posedge clk_i);
        check(moves != 0, 1);
        // steps taken before the new offset landed are flushed untracked
        track = 0;
        wb(1, REG_OFFSET, 32'h0030_0000, 4'hf);
        {have_prev, dec, moves} = 0;
        repeat (12) @(posedge clk_i);
        track = 1;
        repeat (300) @(posedge clk_i);
        check(moves != 0, 1);
        track = 0;
        user_req_i <= 1;
        n = 0;
        do @(negedge clk_i); while (cfg_port_busy_o !== 1'b0 && ++n < 30);
        check(cfg_port_busy_o, 0);
        user_acc(1, 8'h5a, 16'hbeef, 1);
        slow = 1;
        user_acc(0, 8'ha5, 16'h0f0f, 1);
        @(posedge clk_i);
        user_req_i <= 0;
        @(posedge clk_i);
        @(negedge clk_i);
        check(cfg_port_busy_o, 1);
        user_acc(1, 8'h33, 16'h1234, 0);
        n = 0;
        repeat (40) @(negedge clk_i) if (cfg_enable_o) n++;
        check(n, 0);
        wb(0, REG_STATUS, 0, 4'hf);
        check(rd[STAT_HALT_BIT], 1);
        @(posedge clk_i);
        rst_i <= 1;
        @(posedge clk_i);
        rst_i <= 0;
        @(negedge clk_i);
        check({cfg_port_busy_o, cfg_enable_o, user_cfg_ready_mirror_o}, 3'b100);
        wb(0, REG_STATUS, 0, 4'hf);
        check(rd[STAT_HALT_BIT], 0);
        wb(1, REG_OFFSET, 32'h0010_0000, 4'hf);
        wb(1, REG_CTRL, CTRL_RST | 32'h1, 4'hf);
        n = 0;
        while (cfg_enable_o !== 1'b1 && ++n < 200) @(negedge clk_i);
        check(cfg_enable_o, 1);
        summarize();
    end
endmodule
`default_nettype wire
